/* File: design/cb_channel_timer.sv */
`timescale 1ns/1ps
`default_nettype none
// one balancing channel: loads its setting on go, counts down on tick while balancing
module cb_channel_timer #(
  parameter int TW = 8
) (
  input wire logic clk, // clock
  input wire logic rstn, // sync reset, active low
  input wire logic ce, // clock enable
  input wire logic load, // go accepted: take setting
  input wire logic clear, // stop: zero the timer
  input wire logic [TW-1:0] setting, // channel timer setting
  input wire logic count, // tick while running, not paused and armed, whether the switch is on or not
  output logic armed // timer non-zero
);
  logic [TW-1:0] cnt_r;
  logic [TW-1:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (clear) begin
      cnt_nxt = '0;
    end else if (load) begin
      cnt_nxt = setting;
    end else if (count && cnt_r != '0) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_r <= '0;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
    end
  end

  assign armed = (cnt_r != '0);
endmodule // cb_channel_timer
`default_nettype wire

/* File: design/cell_balance_start_control.sv */
// Contract
// - every one of sixteen channels owns its own balancing timer setting
// - a non-zero setting only arms; switches wait for the go bit
// - an expired timer stops only its own channel
// - running flag is high exactly while balancing is in progress
// - channels above the highest active channel never switch on
// - balancing runs on alone, also while the device sleeps
// - low voltage, unmasked fault or host stop also end balancing
// - auto mode accepts any channel mix and starts on go
// - auto mode alternates odd and even switches with the duty field
// - auto mode with only odd or only even does not alternate
// - manual mode turns on every armed switch, no alternation
// - invalid manual selection on go: no start, invalid flag set
// - more than eight non-zero settings within the active range is invalid
// - no-adjacent set and any two neighbours enabled is invalid
// - no-adjacent clear and three consecutive enabled is invalid
// - pause turns switches off, freezes timers, sets in-pause flag
// - done flag when every enabled channel stopped by its timer or by low voltage, not on stop or fault
// - go with all settings zero starts nothing, done stays low
`timescale 1ns/1ps
`default_nettype none
module cell_balance_start_control
  import cb_pkg::*;
#(
  parameter int N = cb_pkg::NUM_CH,
  parameter int TICK = cb_pkg::TICK_CYC,
  parameter int SLOT = cb_pkg::DUTY_SLOT_CYC
) (
  input wire logic clk, // 250 MHz clock
  input wire logic rstn, // sync reset, active low
  input wire logic ce, // clock enable, freezes everything when low
  input wire logic [N*cb_pkg::TIMER_W-1:0] channel_timer_setting, // per-channel timer
  input wire cb_pkg::cb_config_t cfg, // control and configuration bits
  input wire logic balance_go_bit, // go pulse from host write
  input wire logic pause_req, // host pause request level
  input wire logic thermal_pause, // thermal pause level (pin)
  input wire logic force_stop, // host forced stop pulse
  input wire logic fault_stop_en, // stop on unmasked fault enable
  input wire logic unmasked_fault, // unmasked fault level (pin)
  input wire logic [N-1:0] below_threshold, // per-channel low voltage level (pins)
  input wire logic sleep_mode, // power state, does not affect balancing
  output cb_pkg::cb_status_t balance_status, // status flags
  output logic [N-1:0] balancing_switch // switch drive
);
  import cb_pkg::*;

  typedef enum {ST_IDLE, ST_RUN} st_t;

  // three-stage sync for pin inputs; change counted once stages 2 and 3 agree
  logic [N+1:0] sy1_r, sy2_r, sy3_r, flt_r;
  logic [N+1:0] raw_in;
  logic [N+1:0] flt_nxt;
  assign raw_in = {thermal_pause, unmasked_fault, below_threshold};

  always_comb begin
    flt_nxt = flt_r;
    for (int i = 0; i < N + 2; i++) begin
      if (sy2_r[i] == sy3_r[i]) flt_nxt[i] = sy3_r[i];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      sy1_r <= '0;
      sy2_r <= '0;
      sy3_r <= '0;
      flt_r <= '0;
    end else if (ce) begin
      sy1_r <= raw_in;
      sy2_r <= sy1_r;
      sy3_r <= sy2_r;
      flt_r <= flt_nxt;
    end
  end

  logic therm_s, fault_s;
  logic [N-1:0] low_v_s;
  assign therm_s = flt_r[N+1];
  assign fault_s = flt_r[N];
  assign low_v_s = flt_r[N-1:0];

  // channel selection from settings and active cell count
  logic [N-1:0] nz, act_mask, sel;
  always_comb begin
    for (int i = 0; i < N; i++) begin
      nz[i] = channel_timer_setting[i*TIMER_W +: TIMER_W] != '0;
      act_mask[i] = (i <= int'(cfg.highest_active_channel));
    end
    sel = nz & act_mask;
  end

  // manual selection validity
  logic [4:0] sel_cnt;
  logic adj2, adj3, invalid;
  always_comb begin
    sel_cnt = '0;
    adj2 = 1'b0;
    adj3 = 1'b0;
    for (int i = 0; i < N; i++) sel_cnt = sel_cnt + 5'(sel[i]);
    for (int i = 0; i < N - 1; i++) if (sel[i] && sel[i+1]) adj2 = 1'b1;
    for (int i = 0; i < N - 2; i++) if (sel[i] && sel[i+1] && sel[i+2]) adj3 = 1'b1;
    invalid = (sel_cnt > 5'(MAX_MANUAL_CH))
      || (cfg.no_adjacent_bit && adj2)
      || (!cfg.no_adjacent_bit && adj3);
  end

  // control state
  st_t st_r, st_nxt;
  logic auto_r, auto_nxt;
  logic [DUTY_W-1:0] duty_r, duty_nxt;
  logic [N-1:0] en_r, en_nxt; // enabled at go
  logic [N-1:0] vstop_r, vstop_nxt; // stopped by low voltage
  logic done_r, done_nxt, inval_r, inval_nxt, abort_r, abort_nxt;
  logic [31:0] tick_r, tick_nxt;
  logic [31:0] slot_r, slot_nxt;
  logic [DUTY_W:0] phase_r, phase_nxt;
  logic odd_r, odd_nxt;
  logic [N-1:0] sw_r, sw_nxt;
  logic run_r, run_nxt, pause_r, pause_nxt;

  logic [N-1:0] armed;
  logic load, clr_all, tick;
  logic [N-1:0] clr_ch;
  logic paused, go_ok;

  assign paused = pause_req || therm_s;
  assign tick = (tick_r == 32'(TICK - 1));
  // go accepted when something is armed and, in manual, the selection is valid
  assign go_ok = balance_go_bit && (sel != '0)
    && (cfg.auto_control_bit || !invalid);
  assign load = go_ok;
  // an unmasked fault aborts only when not paused
  assign clr_all = force_stop
    || (st_r == ST_RUN && fault_stop_en && fault_s && !paused);
  assign clr_ch = {N{clr_all}} | (low_v_s & en_r & {N{st_r == ST_RUN}});

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : ch
      cb_channel_timer #(.TW(TIMER_W)) u_tmr (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .load(load),
        .clear(clr_ch[g] || (load && !sel[g])),
        .setting(channel_timer_setting[g*TIMER_W +: TIMER_W]),
        .count(st_r == ST_RUN && !paused && armed[g] && tick),
        .armed(armed[g])
      );
    end
  endgenerate

  // odd switches are even bit indices (channel 1 is bit 0)
  logic [N-1:0] odd_m;
  logic has_odd, has_even, alt;
  always_comb begin
    for (int i = 0; i < N; i++) odd_m[i] = (i % 2 == 0);
    has_odd = (armed & odd_m) != '0;
    has_even = (armed & ~odd_m) != '0;
    alt = auto_r && has_odd && has_even;
  end

  always_comb begin
    st_nxt = st_r;
    auto_nxt = auto_r;
    duty_nxt = duty_r;
    en_nxt = en_r;
    vstop_nxt = vstop_r;
    done_nxt = done_r;
    inval_nxt = inval_r;
    abort_nxt = abort_r;
    tick_nxt = tick_r;
    slot_nxt = slot_r;
    phase_nxt = phase_r;
    odd_nxt = odd_r;
    sw_nxt = '0;
    run_nxt = 1'b0;
    pause_nxt = 1'b0;
    case (st_r)
      ST_IDLE: begin
        tick_nxt = '0;
      end
      ST_RUN: begin
        // runs regardless of sleep_mode, no host action needed
        tick_nxt = tick ? '0 : tick_r + 32'h1;
        if (paused) tick_nxt = tick_r;
        vstop_nxt = vstop_r | (low_v_s & en_r);
        if (!paused && alt) begin
          // duty slots: odd side gets duty+1 slots out of 8, even the rest
          if (slot_r == 32'(SLOT - 1)) begin
            slot_nxt = '0;
            phase_nxt = phase_r + 1'b1;
          end else begin
            slot_nxt = slot_r + 32'h1;
          end
          odd_nxt = (phase_r[DUTY_W-1:0] <= duty_r);
        end
        if (!paused) begin
          if (alt) begin
            sw_nxt = armed & (odd_nxt ? odd_m : ~odd_m);
          end else begin
            sw_nxt = armed;
          end
        end
        pause_nxt = paused;
        run_nxt = 1'b1;
        if (armed == '0 || clr_all) begin
          st_nxt = ST_IDLE;
          sw_nxt = '0;
          run_nxt = 1'b0;
          pause_nxt = 1'b0;
          done_nxt = !clr_all;
          abort_nxt = clr_all && !force_stop;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
    // masked here so the switch output stays a plain register
    sw_nxt = sw_nxt & act_mask;
    if (balance_go_bit) begin
      inval_nxt = !cfg.auto_control_bit && invalid && (sel != '0);
      done_nxt = 1'b0;
      if (go_ok) begin
        st_nxt = ST_RUN;
        auto_nxt = cfg.auto_control_bit;
        duty_nxt = cfg.alternation_duty_field;
        en_nxt = sel;
        vstop_nxt = '0;
        abort_nxt = 1'b0;
        slot_nxt = '0;
        phase_nxt = '0;
        odd_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_r <= ST_IDLE;
      auto_r <= 1'b0;
      duty_r <= DUTY_RST;
      en_r <= '0;
      vstop_r <= '0;
      done_r <= 1'b0;
      inval_r <= 1'b0;
      abort_r <= 1'b0;
      tick_r <= '0;
      slot_r <= '0;
      phase_r <= '0;
      odd_r <= 1'b1;
      sw_r <= '0;
      run_r <= 1'b0;
      pause_r <= 1'b0;
    end else if (ce) begin
      st_r <= st_nxt;
      auto_r <= auto_nxt;
      duty_r <= duty_nxt;
      en_r <= en_nxt;
      vstop_r <= vstop_nxt;
      done_r <= done_nxt;
      inval_r <= inval_nxt;
      abort_r <= abort_nxt;
      tick_r <= tick_nxt;
      slot_r <= slot_nxt;
      phase_r <= phase_nxt;
      odd_r <= odd_nxt;
      sw_r <= sw_nxt;
      run_r <= run_nxt;
      pause_r <= pause_nxt;
    end
  end

  assign balancing_switch = sw_r;
  assign balance_status = {
    run_r,
    pause_r,
    done_r,
    inval_r,
    abort_r
  };
endmodule // cell_balance_start_control
`default_nettype wire

/* File: dv/cb_checker_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module cb_checker
  import cb_pkg::*;
#(
  parameter int N = 16
) (
  input wire logic clk, // clock
  input wire logic rstn, // sync reset, active low
  input wire logic ce, // clock enable
  input wire logic [N*cb_pkg::TIMER_W-1:0] channel_timer_setting, // settings
  input wire cb_pkg::cb_config_t cfg, // configuration
  input wire logic balance_go_bit, // go pulse
  input wire cb_pkg::cb_status_t balance_status, // status flags
  input wire logic [N-1:0] balancing_switch // switch drive
);
  logic [N-1:0] act, en;
  logic go, gm, a2, a3, ok, run;
  int cnt;
  assign act = N'((32'h2 << cfg.highest_active_channel) - 32'h1);
  always_comb begin
    for (int i = 0; i < N; i++) en[i] = act[i] && (|channel_timer_setting[i*TIMER_W+:TIMER_W]);
  end
  assign cnt = $countones(en);
  assign go = ce && balance_go_bit;
  assign gm = go && !cfg.auto_control_bit;
  assign a2 = |(en & (en >> 1));
  assign a3 = |(en & (en >> 1) & (en >> 2));
  assign ok = cnt <= MAX_MANUAL_CH && !(cfg.no_adjacent_bit ? a2 : a3);
  assign run = balance_status.balance_running_flag;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence run_s; run; endsequence
  sequence sel_on_s; balancing_switch == en; endsequence
  act_mask_a: assert property ((balancing_switch & ~act) == '0)
    else $error("switch on above active range");
  pause_off_a: assert property (balance_status.in_pause_flag |-> balancing_switch == '0)
    else $error("switch on during pause");
  idle_off_a: assert property (!run |-> balancing_switch == '0)
    else $error("switch on while not running");
  run_cause_a: assert property ($rose(run) |-> $past(go, 2))
    else $error("running without go");
  many_ch_a: assert property (gm && cnt > 8 |=> balance_status.invalid_selection_flag ##1 !run)
    else $error("too many channels accepted");
  adj_pair_a: assert property (gm && cfg.no_adjacent_bit && a2 |=> balance_status.invalid_selection_flag)
    else $error("neighbours accepted");
  adj_three_a: assert property (gm && !cfg.no_adjacent_bit && a3 |=> balance_status.invalid_selection_flag ##1 !run)
    else $error("three in a row accepted");
  zero_go_a: assert property (go && cnt == 0 |=> ##1 (!run && !balance_status.balancing_done_flag))
    else $error("empty go started");
  manual_on_a: assert property (gm && ok && cnt != 0 |-> ##2 run_s ##0 sel_on_s)
    else $error("manual switches wrong");
  auto_go_a: assert property (go && cfg.auto_control_bit && cnt != 0 |-> ##2 run_s)
    else $error("auto did not start");
endmodule // cb_checker
bind cell_balance_start_control cb_checker #(.N(N)) u_chk (.clk(clk), .rstn(rstn), .ce(ce),
  .channel_timer_setting(channel_timer_setting), .cfg(cfg), .balance_go_bit(balance_go_bit),
  .balance_status(balance_status), .balancing_switch(balancing_switch));
`default_nettype wire

/* File: dv/cell_balance_start_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module cell_balance_start_control_tb;
  import cb_pkg::*;
  typedef struct {logic [4:0] st; logic [4:0] sm; logic [15:0] sw; logic [15:0] wm;} note_t;
  logic clk = 0, rstn = 0, go = 0, pz = 0, fs = 0, fe = 0, uf = 0, sl = 0, look = 0;
  logic [127:0] set = '0;
  cb_config_t cfg = '0;
  cb_status_t st;
  logic [15:0] sw;
  logic [15:0] lv = '0;
  note_t q[$];
  int n_fail = 0, n_checks = 0;
  always #2 clk = ~clk;
  cell_balance_start_control #(.TICK(4), .SLOT(3)) DUT (.clk(clk), .rstn(rstn), .ce(1'h1),
    .channel_timer_setting(set), .cfg(cfg), .balance_go_bit(go), .pause_req(pz),
    .thermal_pause(1'h0), .force_stop(fs), .fault_stop_en(fe), .unmasked_fault(uf),
    .below_threshold(lv), .sleep_mode(sl), .balance_status(st), .balancing_switch(sw));
  task stop_test;
    if (n_fail == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // oldest note is compared against the values settled by the previous edge
  always @(posedge clk) if (look) begin
    note_t n;
    n = q.pop_front();
    n_checks++;
    if (((st & n.sm) !== (n.st & n.sm)) || ((sw & n.wm) !== (n.sw & n.wm))) begin
      n_fail++;
      $display("[FAIL] %0t status %h switches %h", $time, st, sw);
    end
  end
  task note(input logic [4:0] s, m, input logic [15:0] w, wm);
    q.push_back('{s, m, w, wm});
    look = 1;
    @(negedge clk);
    look = 0;
  endtask
  // timers of at least two ticks so no channel expires before the switch check
  function automatic logic [127:0] mk(input logic [15:0] m);
    logic [127:0] r;
    r = '0;
    for (int i = 0; i < 16; i++) if (m[i]) r[i*8+:8] = 8'($urandom_range(8, 2));
    return r;
  endfunction
  task start(input logic [15:0] m, input logic a, na, input logic [3:0] hi);
    set = mk(m);
    cfg = '{a, na, 3'h2, hi};
    go = 1;
    @(negedge clk);
    go = 0;
    repeat (2) @(negedge clk);
  endtask
  task wt(input int b, input logic v);
    int i;
    for (i = 0; i < 400 && st[b] !== v; i++) @(negedge clk);
    if (i == 400) begin
      n_fail++;
      $display("[FAIL] %0t wait timed out", $time);
      stop_test;
    end
  endtask
  initial begin
    void'($urandom(32'hA6C238B0));
    repeat (5) @(negedge clk);
    rstn = 1;
    start(16'h2A5B, 0, 0, 4'hF);
    note(5'h10, 5'h1F, 16'h2A5B, 16'hFFFF);
    wt(2, 1);
    note(5'h04, 5'h1F, 16'h0000, 16'hFFFF);
    start(16'h0007, 0, 0, 4'hF);
    note(5'h02, 5'h1F, 16'h0000, 16'hFFFF);
    start(16'h0003, 0, 1, 4'hF);
    note(5'h02, 5'h1F, 16'h0000, 16'hFFFF);
    start(16'hD555, 0, 0, 4'hF);
    note(5'h02, 5'h1F, 16'h0000, 16'hFFFF);
    start(16'h0000, 0, 0, 4'hF);
    note(5'h00, 5'h1F, 16'h0000, 16'hFFFF);
    start(16'h0055, 0, 0, 4'h3);
    note(5'h10, 5'h1F, 16'h0005, 16'hFFFF);
    wt(2, 1);
    sl = 1;
    start(16'h5555, 1, 0, 4'hF);
    note(5'h10, 5'h1F, 16'h5555, 16'hFFFF);
    pz = 1;
    wt(3, 1);
    note(5'h18, 5'h1F, 16'h0000, 16'hFFFF);
    pz = 0;
    wt(3, 0);
    fs = 1;
    @(negedge clk);
    fs = 0;
    wt(4, 0);
    note(5'h00, 5'h1F, 16'h0000, 16'hFFFF);
    sl = 0;
    start(16'hFFFF, 1, 0, 4'hF);
    // odd switches lead the alternation frame
    note(5'h10, 5'h1F, 16'h5555, 16'hFFFF);
    fe = 1;
    uf = 1;
    wt(0, 1);
    note(5'h01, 5'h1F, 16'h0000, 16'hFFFF);
    fe = 0;
    uf = 0;
    // long timer so only the low-voltage input can end this run
    set = 128'h0;
    set[7:0] = 8'hFF;
    cfg = '{1'b0, 1'b0, 3'h2, 4'hF};
    go = 1;
    @(negedge clk);
    go = 0;
    lv = 16'h0001;
    wt(2, 1);
    note(5'h04, 5'h1F, 16'h0000, 16'hFFFF);
    stop_test;
  end
endmodule // cell_balance_start_control_tb
`default_nettype wire

/* File: include/cb_pkg.sv */
package cb_pkg;
  localparam int NUM_CH = 16;
  localparam int TIMER_W = 8;
  localparam int DUTY_W = 3;
  localparam int CELLS_W = 4;
  localparam int MAX_MANUAL_CH = 8;
  // tick period for timer countdown, in microseconds
  localparam int TICK_US = 1000;
  localparam int CLK_MHZ = 250;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;
  // one duty slot of the odd/even alternation, in microseconds
  localparam int DUTY_SLOT_US = 1000;
  localparam int DUTY_SLOT_CYC = DUTY_SLOT_US * CLK_MHZ;
  localparam logic [DUTY_W-1:0] DUTY_RST = 3'h0;
  localparam logic [CELLS_W-1:0] CELLS_RST = 4'hF;

  typedef struct packed {
    logic auto_control_bit;
    logic no_adjacent_bit;
    logic [DUTY_W-1:0] alternation_duty_field;
    logic [CELLS_W-1:0] highest_active_channel;
  } cb_config_t;

  typedef struct packed {
    logic balance_running_flag;
    logic in_pause_flag;
    logic balancing_done_flag;
    logic invalid_selection_flag;
    logic abort_fault_flag;
  } cb_status_t;
endpackage
